// ---- hw/rsse_pkg.sv ----
// shared constants for the rotate/subtract/halt execution core
package rsse_pkg;
  // register byte offsets on the axi4-lite bus
  localparam int             AXI_AW        = 8;
  localparam logic [7:0]     ADDR_CMD      = 8'h00;
  localparam logic [7:0]     ADDR_ACC      = 8'h04;
  localparam logic [7:0]     ADDR_STATUS   = 8'h08;
  localparam logic [7:0]     ADDR_WDOG     = 8'h0c;
  localparam logic [7:0]     ADDR_MEM_ADDR = 8'h10;
  localparam logic [7:0]     ADDR_MEM_DATA = 8'h14;

  // command register fields
  localparam int             CMD_OP_LSB    = 0;
  localparam int             CMD_DEST_BIT  = 2;
  localparam int             CMD_FADDR_LSB = 8;
  localparam int             CMD_LIT_LSB   = 16;

  // operation codes in the command register
  localparam logic [1:0]     ROTATE_LEFT_OP       = 2'h0;
  localparam logic [1:0]     ROTATE_RIGHT_OP      = 2'h1;
  localparam logic [1:0]     LITERAL_MINUS_ACC_OP = 2'h2;
  localparam logic [1:0]     HALT_OP              = 2'h3;

  // status register bit positions
  localparam int             ST_CARRY      = 0;
  localparam int             ST_NIBBLE     = 1;
  localparam int             ST_ZERO       = 2;
  localparam int             ST_PD         = 3;
  localparam int             ST_TO         = 4;
  localparam int             ST_SLEEP      = 5;

  // values after reset
  localparam logic [7:0]     RST_ACC       = 8'h00;
  localparam logic [31:0]    RST_CMD       = 32'h0000_0000;
  localparam logic           RST_PD        = 1'b1;
  localparam logic           RST_TO        = 1'b1;
  localparam int             WDOG_W        = 8;
  localparam logic [7:0]     WDOG_CLEAR    = 8'h00;

  // axi response codes
  localparam logic [1:0]     RESP_OKAY     = 2'b00;
  localparam logic [1:0]     RESP_SLVERR   = 2'b10;

  typedef enum logic {CORE_RUN, CORE_SLEEP} rsse_state_e;
endpackage

// ---- hw/rsse_alu_if.sv ----
// operand and result bundle between the core and its datapath
`timescale 1ns/1ps
interface rsse_alu_if;
  logic [1:0] op;
  logic [7:0] operand;
  logic [7:0] literal;
  logic [7:0] acc;
  logic       carry_in;
  logic [7:0] result;
  logic       carry_out;
  logic       nibble_out;
  logic       zero_out;

  modport alu  (input  op, operand, literal, acc, carry_in,
                output result, carry_out, nibble_out, zero_out);
  modport core (output op, operand, literal, acc, carry_in,
                input  result, carry_out, nibble_out, zero_out);
endinterface

// ---- hw/rsse_alu.sv ----
// combinational datapath for rotate and literal-subtract operations
`timescale 1ns/1ps
module rsse_alu
  import rsse_pkg::*;
(
  rsse_alu_if.alu bus
);
  logic [8:0] diff;

  // one result per operation; flags not used by an op are don't-care to the core
  always_comb begin
    diff           = {1'b0, bus.literal} - {1'b0, bus.acc};
    bus.result     = bus.acc;
    bus.carry_out  = bus.carry_in;
    bus.nibble_out = 1'b0;
    bus.zero_out   = 1'b0;
    case (bus.op)
      ROTATE_LEFT_OP: begin
        bus.result    = {bus.operand[6:0], bus.carry_in};
        bus.carry_out = bus.operand[7];
      end
      ROTATE_RIGHT_OP: begin
        bus.result    = {bus.carry_in, bus.operand[7:1]};
        bus.carry_out = bus.operand[0];
      end
      LITERAL_MINUS_ACC_OP: begin
        bus.result     = diff[7:0];
        bus.carry_out  = (bus.acc <= bus.literal);
        bus.nibble_out = (bus.acc[3:0] <= bus.literal[3:0]);
        bus.zero_out   = (diff[7:0] == 8'h00);
      end
      default: begin
        bus.result = bus.acc;
      end
    endcase
  end
endmodule

// ---- hw/rsse_core.sv ----
// execution core for rotate, literal-subtract and halt, with axi4-lite registers
// Contract
// - left rotate: shift up, old carry into bit 0, bit 7 to carry
// - rotate destination bit 0 writes accumulator, 1 writes source register
// - right rotate: shift down, old carry into bit 7, bit 0 to carry
// - right rotate destination bit 0 to accumulator, 1 back to source
// - halt clears power-down status, sets timeout status, no other flags
// - halt clears the watchdog counter and its prescaler
// - after halt the core sleeps, oscillator stopped, until wake-up
// - literal-subtract computes literal minus accumulator into accumulator
// - carry and nibble borrow are 0 when accumulator part exceeds literal part
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module rsse_core
  import rsse_pkg::*;
#(
  parameter int FADDR_W = 7,
  parameter int PRESC_W = 8
)(
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  input  wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  input  wire logic              i_wake,
  output logic                   o_osc_stop
);
  localparam int MEM_DEPTH = 2 ** FADDR_W;
  // refuse sizes that the command fields cannot carry
  if (FADDR_W < 1 || FADDR_W > 8 || PRESC_W < 1 || PRESC_W > 16) begin
    $error("FADDR_W must lie in 1..8 and PRESC_W in 1..16");
  end
  // write channel state
  logic              awready_reg, awready_next;
  logic              wready_reg, wready_next;
  logic              aw_full_reg, aw_full_next;
  logic              w_full_reg, w_full_next;
  logic [AXI_AW-1:0] waddr_reg, waddr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [3:0]        wstrb_reg, wstrb_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  // read channel state
  logic              arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  // core state
  rsse_state_e       state_reg, state_next;
  logic              osc_stop_reg, osc_stop_next;
  logic [31:0]       cmd_reg, cmd_next;
  logic [7:0]        acc_reg, acc_next;
  logic              carry_reg, carry_next;
  logic              nibble_reg, nibble_next;
  logic              zero_reg, zero_next;
  logic              pd_reg, pd_next;
  logic              to_reg, to_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  logic [WDOG_W-1:0] wdog_reg, wdog_next;
  logic [FADDR_W-1:0] mem_addr_reg, mem_addr_next;
  logic [7:0]        mem_reg [MEM_DEPTH];
  logic [7:0]        mem_next [MEM_DEPTH];
  logic              wr_go;
  logic [31:0]       wr_merged;
  logic [FADDR_W-1:0] fidx;
  logic              presc_tick;
  rsse_alu_if alu_bus ();
  // true for every offset that answers okay
  function automatic logic addr_hit(input logic [AXI_AW-1:0] a);
    return (a == ADDR_CMD) || (a == ADDR_ACC) || (a == ADDR_STATUS) ||
           (a == ADDR_WDOG) || (a == ADDR_MEM_ADDR) || (a == ADDR_MEM_DATA);
  endfunction

  // current read value of a register; also the base for byte-lane merges
  function automatic logic [31:0] reg_value(input logic [AXI_AW-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == ADDR_CMD) begin
      v = cmd_reg;
    end else if (a == ADDR_ACC) begin
      v[7:0] = acc_reg;
    end else if (a == ADDR_STATUS) begin
      v[ST_CARRY]  = carry_reg;
      v[ST_NIBBLE] = nibble_reg;
      v[ST_ZERO]   = zero_reg;
      v[ST_PD]     = pd_reg;
      v[ST_TO]     = to_reg;
      v[ST_SLEEP]  = (state_reg == CORE_SLEEP);
    end else if (a == ADDR_WDOG) begin
      v[WDOG_W-1:0] = wdog_reg;
    end else if (a == ADDR_MEM_ADDR) begin
      v[FADDR_W-1:0] = mem_addr_reg;
    end else if (a == ADDR_MEM_DATA) begin
      v[7:0] = mem_reg[mem_addr_reg];
    end
    return v;
  endfunction
  // apply the write strobes byte by byte over the old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction
  // a write is performed once address and data are both held
  assign wr_go     = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_merged = merge(reg_value(waddr_reg), wdata_reg, wstrb_reg);
  assign fidx      = wr_merged[CMD_FADDR_LSB +: FADDR_W];
  // datapath op, literal and register index come straight from the command being written; acc and carry from their registers
  assign alu_bus.op       = wr_merged[CMD_OP_LSB +: 2];
  assign alu_bus.operand  = mem_reg[fidx];
  assign alu_bus.literal  = wr_merged[CMD_LIT_LSB +: 8];
  assign alu_bus.acc      = acc_reg;
  assign alu_bus.carry_in = carry_reg;
  rsse_alu u_alu (
    .bus (alu_bus.alu)
  );
  // write channels: address and data are taken in either order, one write at a time
  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (i_s_axi_awvalid && awready_reg) begin
      waddr_next   = i_s_axi_awaddr;
      aw_full_next = 1'b1;
      awready_next = 1'b0;
    end
    if (i_s_axi_wvalid && wready_reg) begin
      wdata_next  = i_s_axi_wdata;
      wstrb_next  = i_s_axi_wstrb;
      w_full_next = 1'b1;
      wready_next = 1'b0;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_hit(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    // ready stays low until the response is taken, so no second write overlaps
    if (bvalid_reg && i_s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // read channel: data is sampled at the address handshake
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (i_s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = reg_value(i_s_axi_araddr);
      rresp_next   = addr_hit(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_reg && i_s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end
  // prescaler overflow is the one-cycle enable of the watchdog counter
  assign presc_tick = (presc_reg == {PRESC_W{1'b1}});
  // core: register writes, single-cycle execution, sleep and watchdog
  always_comb begin
    state_next    = state_reg;
    osc_stop_next = osc_stop_reg;
    cmd_next      = cmd_reg;
    acc_next      = acc_reg;
    carry_next    = carry_reg;
    nibble_next   = nibble_reg;
    zero_next     = zero_reg;
    pd_next       = pd_reg;
    to_next       = to_reg;
    mem_addr_next = mem_addr_reg;
    mem_next      = mem_reg;
    presc_next    = PRESC_W'(presc_reg + 1'b1);
    wdog_next     = presc_tick ? WDOG_W'(wdog_reg + 1'b1) : wdog_reg;
    // a wake-up restarts the oscillator; the watchdog runs on regardless
    if (state_reg == CORE_SLEEP && i_wake) begin
      state_next    = CORE_RUN;
      osc_stop_next = 1'b0;
    end
    if (wr_go) begin
      if (waddr_reg == ADDR_CMD) begin
        cmd_next = wr_merged;
        // commands written while asleep are stored but not run
        if (state_reg == CORE_RUN) begin
          case (alu_bus.op)
            ROTATE_LEFT_OP, ROTATE_RIGHT_OP: begin
              carry_next = alu_bus.carry_out;
              if (wr_merged[CMD_DEST_BIT]) begin
                mem_next[fidx] = alu_bus.result;
              end else begin
                acc_next = alu_bus.result;
              end
            end
            LITERAL_MINUS_ACC_OP: begin
              acc_next    = alu_bus.result;
              carry_next  = alu_bus.carry_out;
              nibble_next = alu_bus.nibble_out;
              zero_next   = alu_bus.zero_out;
            end
            default: begin
              pd_next       = 1'b0;
              to_next       = 1'b1;
              wdog_next     = WDOG_CLEAR;
              presc_next    = '0;
              state_next    = CORE_SLEEP;
              osc_stop_next = 1'b1;
            end
          endcase
        end
      end else if (waddr_reg == ADDR_ACC) begin
        acc_next = wr_merged[7:0];
      end else if (waddr_reg == ADDR_STATUS) begin
        carry_next  = wr_merged[ST_CARRY]; // power and time-out bits are read only
        nibble_next = wr_merged[ST_NIBBLE];
        zero_next   = wr_merged[ST_ZERO];
      end else if (waddr_reg == ADDR_MEM_ADDR) begin
        mem_addr_next = wr_merged[FADDR_W-1:0];
      end else if (waddr_reg == ADDR_MEM_DATA) begin
        mem_next[mem_addr_reg] = wr_merged[7:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_reg    <= CORE_RUN;
      osc_stop_reg <= 1'b0;
      cmd_reg      <= RST_CMD;
      acc_reg      <= RST_ACC;
      carry_reg    <= 1'b0;
      nibble_reg   <= 1'b0;
      zero_reg     <= 1'b0;
      pd_reg       <= RST_PD;
      to_reg       <= RST_TO;
      mem_addr_reg <= '0;
      presc_reg    <= '0;
      wdog_reg     <= WDOG_CLEAR;
      mem_reg      <= '{default: 8'h00};
    end else begin
      state_reg    <= state_next;
      osc_stop_reg <= osc_stop_next;
      cmd_reg      <= cmd_next;
      acc_reg      <= acc_next;
      carry_reg    <= carry_next;
      nibble_reg   <= nibble_next;
      zero_reg     <= zero_next;
      pd_reg       <= pd_next;
      to_reg       <= to_next;
      mem_addr_reg <= mem_addr_next;
      presc_reg    <= presc_next;
      wdog_reg     <= wdog_next;
      mem_reg      <= mem_next;
    end
  end

  // every output is a flop
  assign o_s_axi_awready = awready_reg;
  assign o_s_axi_wready  = wready_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign o_s_axi_arready = arready_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;
  assign o_osc_stop      = osc_stop_reg;
endmodule

// ---- tb/rsse_core_checker.sv ----
// port-level assertions for the rotate/subtract/halt core
`timescale 1ns/1ps
module rsse_core_checker
  import rsse_pkg::*;
#(
  parameter int PRESC_W = 8
)(
  input wire logic              i_clock,
  input wire logic              i_resetn,
  input wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input wire logic              i_s_axi_awvalid,
  input wire logic              o_s_axi_awready,
  input wire logic [31:0]       i_s_axi_wdata,
  input wire logic              i_s_axi_wvalid,
  input wire logic              o_s_axi_wready,
  input wire logic              o_s_axi_bvalid,
  input wire logic [AXI_AW-1:0] i_s_axi_araddr,
  input wire logic              i_s_axi_arvalid,
  input wire logic              o_s_axi_arready,
  input wire logic [31:0]       o_s_axi_rdata,
  input wire logic              o_s_axi_rvalid,
  input wire logic              i_wake,
  input wire logic              o_osc_stop
);
  // reads this soon after a halt cannot have seen a watchdog tick yet
  localparam int WD_LIM = 2 ** PRESC_W - 8;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [1:0]        w_op_reg;
  logic [AXI_AW-1:0] rd_addr_reg;
  logic              halted_reg;
  logic              osc_q_reg;
  logic [7:0]        since_reg;

  // remember what each handshake carried and how long ago sleep began
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      halted_reg <= 1'b0;
      osc_q_reg  <= 1'b0;
      since_reg  <= 8'hff;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) aw_addr_reg <= i_s_axi_awaddr;
      if (i_s_axi_wvalid && o_s_axi_wready) w_op_reg <= i_s_axi_wdata[1:0];
      if (i_s_axi_arvalid && o_s_axi_arready) rd_addr_reg <= i_s_axi_araddr;
      halted_reg <= halted_reg | o_osc_stop;
      osc_q_reg  <= o_osc_stop;
      if (o_osc_stop && !osc_q_reg) since_reg <= 8'h00;
      else if (since_reg != 8'hff) since_reg <= since_reg + 8'h01;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  halt_sleeps_a: assert property ($rose(o_s_axi_bvalid) && aw_addr_reg == ADDR_CMD &&
    w_op_reg == HALT_OP && !$past(o_osc_stop) |-> o_osc_stop) else $error("halt did not sleep");
  no_false_sleep_a: assert property ($rose(o_osc_stop) |-> $rose(o_s_axi_bvalid) &&
    aw_addr_reg == ADDR_CMD && w_op_reg == HALT_OP) else $error("sleep without halt");
  stay_asleep_a: assert property (o_osc_stop && !i_wake |=> o_osc_stop)
    else $error("woke without wake");
  wake_up_a: assert property (o_osc_stop && i_wake |-> ##[1:2] !o_osc_stop)
    else $error("wake ignored");
  write_cycle_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
    o_s_axi_wready |-> ##1 !o_s_axi_bvalid ##1 o_s_axi_bvalid) else $error("write latency");
  status_pd_a: assert property ($rose(o_s_axi_rvalid) && rd_addr_reg == ADDR_STATUS |->
    o_s_axi_rdata[ST_PD] == !halted_reg) else $error("power down status wrong");
  status_to_a: assert property ($rose(o_s_axi_rvalid) && rd_addr_reg == ADDR_STATUS |->
    o_s_axi_rdata[ST_TO]) else $error("timeout status wrong");
  wdog_clear_a: assert property ($rose(o_s_axi_rvalid) && rd_addr_reg == ADDR_WDOG &&
    since_reg < WD_LIM |-> o_s_axi_rdata[7:0] == 8'h00) else $error("watchdog not cleared");
endmodule

bind rsse_core rsse_core_checker #(.PRESC_W(PRESC_W)) rsse_core_checker_inst (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_s_axi_awaddr(i_s_axi_awaddr),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wvalid(i_s_axi_wvalid),
  .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_wake(i_wake), .o_osc_stop(o_osc_stop));

// ---- tb/tb.sv ----
// self-checking bench for the rotate/subtract/halt core
`timescale 1ns/1ps
module tb;
  import rsse_pkg::*;
  logic              i_clock;
  logic              i_resetn;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp;
  logic [1:0]        bresp_seen;
  logic              i_wake, o_osc_stop;
  logic [4:0]        st_base;
  logic [2:0]        fl_now;
  int                failures = 0;
  int                cmp_count = 0;

  rsse_core #(.FADDR_W(7), .PRESC_W(8)) rsse_core_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_wake(i_wake), .o_osc_stop(o_osc_stop));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ready flags are sampled at the falling edge, where they already equal the next
  // rising-edge value, and the valids drop just after the edge that took them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ag, wg, bg;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(negedge i_clock);
      ag = awvalid & awready;
      wg = wvalid & wready;
      bg = bvalid;
      bresp_seen = bresp;
      @(posedge i_clock);
      if (ag) awvalid <= 1'b0;
      if (wg) wvalid <= 1'b0;
    end while (!bg);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ag, rg;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge i_clock);
      ag = arvalid & arready;
      rg = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge i_clock);
      if (ag) arvalid <= 1'b0;
    end while (!rg);
  endtask

  // expected {acc, source register, zero/nibble/carry}
  function automatic logic [18:0] model(input logic [1:0] op, input logic d,
                                        input logic [7:0] k, a, f, input logic [2:0] fl);
    logic [7:0] r;
    logic [2:0] nf;
    nf = fl;
    case (op)
      ROTATE_LEFT_OP: begin
        r     = {f[6:0], fl[0]};
        nf[0] = f[7];
      end
      ROTATE_RIGHT_OP: begin
        r     = {fl[0], f[7:1]};
        nf[0] = f[0];
      end
      default: begin
        r  = k - a;
        nf = {r == 8'h00, a[3:0] <= k[3:0], a <= k};
      end
    endcase
    if (op == LITERAL_MINUS_ACC_OP || !d) return {r, f, nf};
    return {a, r, nf};
  endfunction

  task automatic run_op(input logic [1:0] op, input logic d, input logic [6:0] ix,
                        input logic [7:0] k, a, f, input logic [2:0] fl);
    logic [18:0] e;
    logic [31:0] v;
    logic [1:0]  r;
    e = model(op, d, k, a, f, fl);
    fl_now = e[2:0];
    wr(ADDR_MEM_ADDR, {25'h0, ix});
    wr(ADDR_MEM_DATA, {24'h0, f});
    wr(ADDR_ACC, {24'h0, a});
    wr(ADDR_STATUS, {29'h0, fl});
    wr(ADDR_CMD, {8'h00, k, 1'b0, ix, 5'h00, d, op});
    rd(ADDR_ACC, v, r);
    chk("acc", v, {24'h0, e[18:11]});
    rd(ADDR_MEM_DATA, v, r);
    chk("register", v, {24'h0, e[10:3]});
    rd(ADDR_STATUS, v, r);
    chk("status", v, {24'h0, st_base, e[2:0]});
  endtask

  task automatic rnd_ops(input int n);
    logic [31:0] x, y;
    for (int i = 0; i < n; i++) begin
      x = $urandom;
      y = $urandom;
      run_op(2'(x % 32'd3), x[2], x[9:3], x[17:10], x[25:18], y[7:0], y[10:8]);
    end
  endtask

  // cut a hang short well past the expected run of about 1600 cycles
  initial begin
    #400000;
    failures++;
    stop_test();
  end

  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid, i_wake, i_resetn} = '0;
    {bready, rready, wstrb} = 6'h3f;
    st_base = 5'b00011;
    void'($urandom(32'hd17daf96));
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    rd(ADDR_STATUS, v, r);
    chk("reset status", v, 32'h18);
    chk("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
    // corner cases: carry in and out, both targets, zero, borrow, equal nibbles
    run_op(ROTATE_LEFT_OP, 1'b0, 7'h05, 8'h00, 8'h3c, 8'he6, 3'b000);
    run_op(ROTATE_RIGHT_OP, 1'b1, 7'h7f, 8'h00, 8'h55, 8'h01, 3'b111);
    run_op(ROTATE_RIGHT_OP, 1'b0, 7'h00, 8'h00, 8'h55, 8'h80, 3'b001);
    run_op(LITERAL_MINUS_ACC_OP, 1'b0, 7'h01, 8'h5a, 8'h5a, 8'h11, 3'b000);
    run_op(LITERAL_MINUS_ACC_OP, 1'b1, 7'h02, 8'h20, 8'h21, 8'h22, 3'b111);
    run_op(LITERAL_MINUS_ACC_OP, 1'b0, 7'h03, 8'h37, 8'h07, 8'h33, 3'b010);
    rnd_ops(30);
    repeat (600) @(posedge i_clock);
    rd(ADDR_WDOG, v, r);
    chk("watchdog running", {31'h0, v != 32'h0}, 32'h1);
    wr(ADDR_CMD, {30'h0, HALT_OP});
    chk("osc stop", {31'h0, o_osc_stop}, 32'h1);
    rd(ADDR_STATUS, v, r);
    chk("halt status", v, {24'h0, 5'b00110, fl_now});
    rd(ADDR_WDOG, v, r);
    chk("watchdog", v, 32'h0);
    // a command while asleep must not run
    // operands chosen so that a rotate run by mistake cannot leave zero behind
    wr(ADDR_ACC, 32'h0);
    wr(ADDR_MEM_ADDR, 32'h0);
    wr(ADDR_MEM_DATA, 32'h81);
    wr(ADDR_CMD, {30'h0, ROTATE_LEFT_OP});
    rd(ADDR_ACC, v, r);
    chk("acc asleep", v, 32'h0);
    i_wake <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_wake <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk("osc awake", {31'h0, o_osc_stop}, 32'h0);
    st_base = 5'b00010;
    rnd_ops(10);
    rd(8'h20, v, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped data", v, 32'h0);
    wr(8'h20, 32'h1);
    chk("unmapped write resp", {30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
    wr(ADDR_ACC, 32'h0000_00a5);
    chk("write resp", {30'h0, bresp_seen}, {30'h0, RESP_OKAY});
    // low byte lane disabled: the accumulator must keep its old value
    wstrb <= 4'he;
    wr(ADDR_ACC, 32'h0000_005a);
    wstrb <= 4'hf;
    rd(ADDR_ACC, v, r);
    chk("masked byte", v, 32'ha5);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    rd(ADDR_STATUS, v, r);
    chk("second reset status", v, 32'h18);
    stop_test();
  end
endmodule
